// >>> rtl/xpd_pkg.sv
// constants and types for the xor and port direction execute block
//
// How it works
// - direction load copies accumulator into direction register 5 to 7
// - direction registers also reached through ordinary file addresses
// - direction load leaves every status flag unchanged
// - literal xor: accumulator xor 8-bit literal into accumulator
// - register xor: accumulator xor addressed file register
// - destination bit 0 writes accumulator, file register untouched
// - destination bit 1 writes file register, accumulator untouched
// - both xor forms update only the zero flag
// - literal xor takes one cycle: decode, read, process, write in q4
package xpd_pkg;
	// ****************
	// encodings
	// ****************
	localparam logic [13:0] XPD_DIR_LOAD_BASE = 14'h0060;
	localparam logic [13:0] XPD_DIR_LOAD_MASK = 14'h3FF8;
	localparam logic [5:0]  XPD_XOR_LIT_OP    = 6'h3A;
	localparam logic [5:0]  XPD_XOR_FILE_OP   = 6'h06;
	localparam logic [2:0]  XPD_DIR_FIRST     = 3'h5;
	localparam logic [2:0]  XPD_DIR_LAST      = 3'h7;
	localparam int          XPD_DEST_BIT      = 7;
	// direction registers as seen in the file map (bank 1 port latches)
	localparam logic [6:0]  XPD_DIR_FILE_BASE = 7'h00;
	localparam logic [7:0]  XPD_DIR_RESET     = 8'hFF;
	localparam logic [7:0]  XPD_ACC_RESET     = 8'h00;

	// ****************
	// quarter cycles
	// ****************
	typedef enum logic [1:0] {
		XPD_Q1 = 2'b00,
		XPD_Q2 = 2'b01,
		XPD_Q3 = 2'b11,
		XPD_Q4 = 2'b10
	} xpd_quarter_t;
endpackage : xpd_pkg

// >>> rtl/xpd_exec.sv
// decode and execute of direction load and the two xor instructions
`timescale 1ns/1ps
module xpd_exec
	import xpd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [13:0] instr,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  file_rdata,
	output logic [6:0]       file_addr,
	output logic [7:0]       file_wdata,
	output logic             file_we,
	output logic [7:0]       acc,
	output logic             zero_flag,
	output logic             zero_we,
	output logic [7:0]       dir_5,
	output logic [7:0]       dir_6,
	output logic [7:0]       dir_7,
	output logic [1:0]       quarter
);
	// ****************
	// quarter sequencer
	// ****************
	xpd_quarter_t q, next_q;
	logic [13:0]  ir, next_ir;
	logic         irv, next_irv;
	logic [7:0]   opnd, next_opnd;
	logic [7:0]   res, next_res;

	function automatic logic [7:0] xpd_xor(input logic [7:0] a, input logic [7:0] b);
		return a ^ b;
	endfunction : xpd_xor

	wire is_dir = ((ir & XPD_DIR_LOAD_MASK) == XPD_DIR_LOAD_BASE) && (ir[2:0] >= XPD_DIR_FIRST);
	wire is_xl  = ir[13:8] == XPD_XOR_LIT_OP;
	wire is_xf  = ir[13:8] == XPD_XOR_FILE_OP;
	wire dest_f = ir[XPD_DEST_BIT];

	// ****************
	// next state
	// ****************
	logic [6:0] next_file_addr;
	logic [7:0] next_file_wdata, next_acc;
	logic       next_file_we, next_zero_flag, next_zero_we;

	always_comb begin
		next_q          = q;
		next_ir         = ir;
		next_irv        = irv;
		next_opnd       = opnd;
		next_res        = res;
		next_file_addr  = file_addr;
		next_file_wdata = file_wdata;
		next_file_we    = 1'b0;
		next_acc        = acc;
		next_zero_flag  = zero_flag;
		next_zero_we    = 1'b0;
		unique case (q)
			XPD_Q1: begin
				next_q         = XPD_Q2;
				next_ir        = instr;
				next_irv       = instr_valid;
				next_file_addr = instr[6:0];
			end
			XPD_Q2: begin
				next_q    = XPD_Q3;
				next_opnd = is_xl ? ir[7:0] : file_rdata;
			end
			XPD_Q3: begin
				next_q   = XPD_Q4;
				next_res = xpd_xor(acc, opnd);
			end
			XPD_Q4: begin
				next_q = XPD_Q1;
				if (irv && (is_xl || is_xf)) begin
					next_zero_flag = (res == 8'h00);
					next_zero_we   = 1'b1;
					if (is_xf && dest_f) begin
						next_file_wdata = res;
						next_file_we    = 1'b1;
					end else begin
						next_acc = res;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q          <= XPD_Q1;
			ir         <= 14'h0000;
			irv        <= 1'b0;
			opnd       <= 8'h00;
			res        <= 8'h00;
			file_addr  <= 7'h00;
			file_wdata <= 8'h00;
			file_we    <= 1'b0;
			acc        <= XPD_ACC_RESET;
			zero_flag  <= 1'b0;
			zero_we    <= 1'b0;
		end else begin
			q          <= next_q;
			ir         <= next_ir;
			irv        <= next_irv;
			opnd       <= next_opnd;
			res        <= next_res;
			file_addr  <= next_file_addr;
			file_wdata <= next_file_wdata;
			file_we    <= next_file_we;
			acc        <= next_acc;
			zero_flag  <= next_zero_flag;
			zero_we    <= next_zero_we;
		end
	end

	// ****************
	// direction latches
	// ****************
	logic [7:0] next_dir_5, next_dir_6, next_dir_7;
	wire        dir_load = (q == XPD_Q4) && irv && is_dir;

	always_comb begin
		next_dir_5 = dir_5;
		next_dir_6 = dir_6;
		next_dir_7 = dir_7;
		// load lands at q4, a file write pulse only stands in q1, so the two never collide
		if (dir_load) begin
			// no flag strobe here, status stays as is
			unique case (ir[1:0])
				2'b01:   next_dir_5 = acc;
				2'b10:   next_dir_6 = acc;
				default: next_dir_7 = acc;
			endcase
		end
		// taken while the write pulse stands; file_addr still holds the writer's address then
		if (file_we && file_addr[6:3] == XPD_DIR_FILE_BASE[6:3]) begin
			unique case (file_addr[2:0])
				3'h5:    next_dir_5 = file_wdata;
				3'h6:    next_dir_6 = file_wdata;
				3'h7:    next_dir_7 = file_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_5 <= XPD_DIR_RESET;
			dir_6 <= XPD_DIR_RESET;
			dir_7 <= XPD_DIR_RESET;
		end else begin
			dir_5 <= next_dir_5;
			dir_6 <= next_dir_6;
			dir_7 <= next_dir_7;
		end
	end

	assign quarter = q;

	// ****************
	// checks
	// ****************
	a_file_xor_write: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && is_xf && dest_f) |=> (file_we && file_wdata == res && acc == $past(acc)))
		else $error("register xor to file wrong");
	a_acc_xor_write: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && (is_xl || (is_xf && !dest_f))) |=> (acc == $past(res) && !file_we))
		else $error("xor to accumulator wrong");
	a_zero_from_res: assert property (@(posedge clk) disable iff (!rst_b)
		zero_we |-> (zero_flag == (acc == 8'h00) || file_we))
		else $error("zero flag mismatch");
	a_dir_no_flag: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && is_dir) |=> (!zero_we && $stable(zero_flag)))
		else $error("direction load touched flags");
	a_dir7_load: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && is_dir && ir[1:0] == 2'b11 && !file_we) |=> dir_7 == $past(acc))
		else $error("direction load lost");
	a_lit_operand: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q2 && is_xl) |=> opnd == $past(ir[7:0]) ##2 q == XPD_Q1)
		else $error("literal not latched");
	a_xor_result: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q3) |=> res == ($past(acc) ^ $past(opnd)))
		else $error("xor result wrong");
	a_dir_file_write: assert property (@(posedge clk) disable iff (!rst_b)
		(file_we && file_addr == 7'h05) |=> dir_5 == $past(file_wdata))
		else $error("direct direction write lost");
	a_file_read_q2: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q2 && is_xf) |=> opnd == $past(file_rdata))
		else $error("file read not in q2");
	a_quarter_walk: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q1) |=> (q == XPD_Q2) ##1 (q == XPD_Q3) ##1 (q == XPD_Q4) ##1 (q == XPD_Q1))
		else $error("quarter order broken");
	a_dir5_load: assert property (@(posedge clk) disable iff (!rst_b)
		(dir_load && ir[1:0] == 2'b01) |=> dir_5 == $past(acc))
		else $error("direction load 5 lost");
	a_dir6_load: assert property (@(posedge clk) disable iff (!rst_b)
		(dir_load && ir[1:0] == 2'b10) |=> dir_6 == $past(acc))
		else $error("direction load 6 lost");
	a_dir_low_refused: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && ir[13:3] == XPD_DIR_LOAD_BASE[13:3] && ir[2:0] < XPD_DIR_FIRST)
			|=> ($stable(dir_5) && $stable(dir_6) && $stable(dir_7)))
		else $error("low direction operand acted");
	a_invalid_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && !irv) |=> (!file_we && !zero_we && $stable(acc)))
		else $error("invalid word acted");
	a_zero_held: assert property (@(posedge clk) disable iff (!rst_b)
		!zero_we |-> $stable(zero_flag))
		else $error("zero flag moved without strobe");
	a_acc_q4_only: assert property (@(posedge clk) disable iff (!rst_b)
		(q != XPD_Q1) |-> $stable(acc))
		else $error("accumulator written outside q4");
	a_pulse_single: assert property (@(posedge clk) disable iff (!rst_b)
		file_we |=> !file_we)
		else $error("file write pulse too long");
	a_addr_latched: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q2) |-> file_addr == ir[6:0])
		else $error("file address not from word");
	a_lit_no_file: assert property (@(posedge clk) disable iff (!rst_b)
		(q == XPD_Q4 && irv && is_xl) |=> (!file_we && zero_we))
		else $error("literal xor wrote file");
endmodule : xpd_exec

// >>> testbench/xor_and_port_direction_exec_tb.sv
// self-checking bench for the xor and port direction execute block
`timescale 1ns/1ps
module xor_and_port_direction_exec_tb;
	import xpd_pkg::*;
	logic        clk, rst_b, iv, fwe, zf, zwe;
	logic [13:0] instr;
	logic [7:0]  rd, wd, acc, d5, d6, d7, m_acc, pv;
	logic [7:0]  m_dir [5:7];
	logic [6:0]  fa;
	logic [1:0]  q;
	logic        m_z;
	logic [31:0] sd;
	int          failures, n_tests, cyc, pend;
	xpd_exec DUT (.clk(clk), .rst_b(rst_b), .instr(instr), .instr_valid(iv), .file_rdata(rd), .file_addr(fa),
		.file_wdata(wd), .file_we(fwe), .acc(acc), .zero_flag(zf), .zero_we(zwe), .dir_5(d5), .dir_6(d6),
		.dir_7(d7), .quarter(q));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [7:0] exp_xor(input logic [7:0] a, input logic [7:0] b);
		return a ^ b;
	endfunction : exp_xor
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// ****************
	// one instruction, launched while quarter is q1
	// ****************
	task automatic ex(input logic [13:0] w, input logic v, input logic [7:0] r);
		logic lit, fil, dl, d;
		logic [7:0] res;
		lit = v && w[13:8] == XPD_XOR_LIT_OP;
		fil = v && w[13:8] == XPD_XOR_FILE_OP;
		dl = v && (w & XPD_DIR_LOAD_MASK) == XPD_DIR_LOAD_BASE && w[2:0] >= XPD_DIR_FIRST;
		d = w[XPD_DEST_BIT];
		res = exp_xor(m_acc, lit ? w[7:0] : r);
		if (pend != 0) m_dir[pend] = pv;
		pend = 0;
		if (dl) m_dir[w[2:0]] = m_acc;
		if (fil && d && w[6:0] - XPD_DIR_FILE_BASE inside {7'h05, 7'h06, 7'h07}) pend = w[2:0];
		pv = res;
		if (lit || (fil && !d)) m_acc = res;
		if (lit || fil) m_z = (res == 8'h00);
		instr = w;
		iv = v;
		rd = r;
		@(posedge clk);
		#1;
		if (fil) chk({1'b0, fa}, w[6:0]);
		repeat (3) @(posedge clk);
		#1;
		chk(acc, m_acc);
		chk({7'h00, zwe}, {7'h00, lit | fil});
		chk({7'h00, zf}, {7'h00, m_z});
		chk({7'h00, fwe}, {7'h00, fil & d});
		if (fil && d) chk(wd, res);
		chk(d5, m_dir[5]);
		chk(d6, m_dir[6]);
		chk(d7, m_dir[7]);
		chk({6'h00, q}, {6'h00, XPD_Q1});
	endtask : ex
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			wrap_up;
		end
	end
	initial begin
		{instr, iv, rd, rst_b, m_z, failures, n_tests, cyc, pend, pv} = '0;
		sd = 32'h0000_62AE;
		m_acc = XPD_ACC_RESET;
		foreach (m_dir[i]) m_dir[i] = XPD_DIR_RESET;
		repeat (20) @(posedge clk);
		#1 rst_b = 1;
		ex({XPD_XOR_LIT_OP, 8'hB5}, 1, 8'h00);
		ex({XPD_XOR_LIT_OP, 8'hB5}, 1, 8'h00);
		ex({XPD_XOR_LIT_OP, 8'hB5}, 1, 8'h00);
		ex({XPD_XOR_FILE_OP, 1'b1, 7'h22}, 1, 8'hAF);
		ex({XPD_XOR_FILE_OP, 1'b0, 7'h7F}, 1, 8'hB5);
		ex({XPD_XOR_LIT_OP, 8'h3C}, 1, 8'h00);
		for (int k = 0; k < 8; k++) ex(XPD_DIR_LOAD_BASE | 14'(k), 1, 8'h00);
		ex({XPD_XOR_FILE_OP, 1'b1, 7'h05}, 1, m_dir[5]);
		ex({XPD_XOR_LIT_OP, 8'h00}, 0, 8'h00);
		$display("corner cases done");
		// ops drawn at random; unknown words must change nothing
		repeat (200) begin
			sd = xs(sd);
			case (sd[1:0])
				2'd0: ex({XPD_XOR_LIT_OP, sd[15:8]}, 1, sd[23:16]);
				2'd1: ex({XPD_XOR_FILE_OP, sd[7], sd[6:0] | 7'h08}, 1, sd[23:16]);
				2'd2: ex(XPD_DIR_LOAD_BASE | {11'h000, sd[10:8]}, 1, sd[23:16]);
				default: ex(sd[29:16], sd[30], sd[23:16]);
			endcase
		end
		$display("random run done");
		wrap_up;
	end
endmodule : xor_and_port_direction_exec_tb
